// ---- cmc_bus_model.sv ----
// bus side model: bit sample ticks and the receive line
// assumes one clock shared with the mode control block
`timescale 1ns/1ns
`default_nettype none
module cmc_bus_model (
    input  wire logic clk_i,
    input  wire logic sof_i,
    output logic      can_rx_o,
    output logic      bit_tick_o
);
    int div = 0;
    int dom = 0;
    // one tick every four clocks, recessive outside a start bit
    always_ff @(posedge clk_i)
    begin
        div        <= (div == 3) ? 0 : div + 1;
        bit_tick_o <= (div == 3);
        dom        <= sof_i ? 4 : ((dom > 0) ? dom - 1 : 0);
        can_rx_o   <= !(sof_i || dom > 1);
    end
endmodule // cmc_bus_model
`default_nettype wire

// ---- cmc_mode_ctrl.sv ----
// mode control and master status of the controller
// assumes a protocol engine on clk_i giving bit ticks and frame events
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_ctrl #(
    parameter int RUN_BITS  = cmc_pkg::RECESSIVE_RUN,
    parameter int RECOVERY_RUNS = cmc_pkg::BUSOFF_RUNS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       can_rx_i,
    input  wire logic       bit_tick_i,
    input  wire logic       rx_start_i,
    input  wire logic       ack_end_i,
    input  wire logic       tx_active_i,
    input  wire logic       tx_end_i,
    input  wire logic       tx_ok_i,
    input  wire logic       error_event_i,
    input  wire logic       busoff_i,
    input  wire logic       fifo_full_i,
    output logic            init_mode_o,
    output logic            sleep_mode_o,
    output logic            tx_order_chronological_o,
    output logic            tx_retry_o,
    output logic            tx_release_o,
    output logic            fifo_store_o,
    output logic            fifo_overwrite_o,
    output logic            fifo_discard_o,
    output logic            busoff_leave_o,
    output logic            irq_o
);
    localparam int BW = $clog2(RECOVERY_RUNS + 1);
    localparam logic [BW-1:0] RUNS_LAST = BW'(RECOVERY_RUNS - 1);
    localparam logic [BW-1:0] RUNS_ONE  = BW'(1);

    initial
    begin
        if (RECOVERY_RUNS < 1) $error("recovery run count must be positive");
    end

    // -------------------------------------------------------------------
    // receive pin synchroniser and frame start
    // -------------------------------------------------------------------
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic rx_prev_reg;
    logic sof;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end
        else
        begin
            rx_meta_reg <= can_rx_i;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    assign sof = rx_prev_reg && !rx_sync_reg;

    // -------------------------------------------------------------------
    // recessive run detection
    // -------------------------------------------------------------------
    logic run_seen;
    logic sync_entry;

    cmc_run_detect #(
        .RUN_LEN    (RUN_BITS)
    ) u_run (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .bit_tick_i (bit_tick_i),
        .rx_i       (rx_sync_reg),
        .clear_i    (sync_entry), // [R08]
        .run_o      (run_seen)
    );

    // -------------------------------------------------------------------
    // mode state and control register
    // -------------------------------------------------------------------
    cmc_pkg::cmc_state_type state_reg;
    cmc_pkg::cmc_state_type state_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic       init_ack_reg;
    logic       init_ack_next;
    logic       receiving_reg;
    logic       busy;
    logic       wr_ctrl;
    logic       sync_done;
    logic       auto_wake;

    assign busy      = receiving_reg || tx_active_i;
    assign wr_ctrl   = wr_i && (addr_i == cmc_pkg::OFS_CTRL);
    assign sync_done = (state_reg == cmc_pkg::ST_SYNC) && run_seen;
    // run count restarts when sync is entered, so a full run follows the release
    assign sync_entry = (state_next == cmc_pkg::ST_SYNC) && (state_reg != cmc_pkg::ST_SYNC);
    assign auto_wake = (state_reg == cmc_pkg::ST_SLEEP) && sof
                       && ctrl_reg[cmc_pkg::CTL_AUTO_WAKE];

    always_comb
    begin
        ctrl_next     = ctrl_reg;
        state_next    = state_reg;
        init_ack_next = init_ack_reg;
        if (wr_ctrl)
            ctrl_next = wdata_i & cmc_pkg::CTL_WMASK; // [R14]
        if (auto_wake)
            ctrl_next[cmc_pkg::CTL_SLEEP_REQ] = 1'b0; // [R02] [R07]
        unique case (state_reg)
            cmc_pkg::ST_SLEEP:
            begin
                if (!ctrl_reg[cmc_pkg::CTL_SLEEP_REQ] || auto_wake) // [R02] [R06]
                begin
                    if (ctrl_reg[cmc_pkg::CTL_INIT_REQ])
                    begin
                        state_next    = cmc_pkg::ST_INIT;
                        init_ack_next = 1'b1;
                    end
                    else
                        state_next = cmc_pkg::ST_SYNC;
                end
            end
            cmc_pkg::ST_INIT:
            begin
                if (ctrl_reg[cmc_pkg::CTL_SLEEP_REQ])
                begin
                    state_next    = cmc_pkg::ST_SLEEP;
                    init_ack_next = 1'b0;
                end
                else if (!ctrl_reg[cmc_pkg::CTL_INIT_REQ])
                    state_next = cmc_pkg::ST_SYNC;
            end
            cmc_pkg::ST_SYNC:
            begin
                if (ctrl_reg[cmc_pkg::CTL_INIT_REQ])
                begin
                    state_next    = cmc_pkg::ST_INIT;
                    init_ack_next = 1'b1;
                end
                else if (run_seen)
                begin
                    state_next    = cmc_pkg::ST_NORMAL; // [R08]
                    init_ack_next = 1'b0;               // [R08]
                end
            end
            cmc_pkg::ST_NORMAL:
            begin
                if (ctrl_reg[cmc_pkg::CTL_INIT_REQ] && !busy)
                begin
                    state_next    = cmc_pkg::ST_INIT; // [R09]
                    init_ack_next = 1'b1;             // [R09]
                end
                else if (ctrl_reg[cmc_pkg::CTL_SLEEP_REQ] && !busy)
                    state_next = cmc_pkg::ST_SLEEP;   // [R06]
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg    <= cmc_pkg::ST_SLEEP;
            ctrl_reg     <= cmc_pkg::CTRL_RESET; // [R10]
            init_ack_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            ctrl_reg     <= ctrl_next;
            init_ack_reg <= init_ack_next;
        end
    end

    // -------------------------------------------------------------------
    // receive timing after acknowledge
    // -------------------------------------------------------------------
    logic [3:0] rx_cnt_reg;
    logic [3:0] rx_cnt_next;
    logic       rx_run_reg;
    logic       rx_run_next;
    logic       receiving_next;
    logic       store_evt;

    assign store_evt = rx_run_reg && bit_tick_i
                       && (rx_cnt_reg == cmc_pkg::STORE_BITS - cmc_pkg::CNT_ONE);

    always_comb
    begin
        rx_cnt_next    = rx_cnt_reg;
        rx_run_next    = rx_run_reg;
        receiving_next = receiving_reg;
        if (rx_start_i)
        begin
            receiving_next = 1'b1;
            rx_run_next    = 1'b0;
            rx_cnt_next    = '0;
        end
        else if (ack_end_i && receiving_reg)
        begin
            rx_run_next = 1'b1;
            rx_cnt_next = '0;
        end
        else if (rx_run_reg && bit_tick_i)
        begin
            rx_cnt_next = rx_cnt_reg + cmc_pkg::CNT_ONE;
            if (rx_cnt_reg == cmc_pkg::RX_END_BITS - cmc_pkg::CNT_ONE)
            begin
                receiving_next = 1'b0; // [R15]
                rx_run_next    = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_cnt_reg    <= '0;
            rx_run_reg    <= 1'b0;
            receiving_reg <= 1'b0;
        end
        else
        begin
            rx_cnt_reg    <= rx_cnt_next;
            rx_run_reg    <= rx_run_next;
            receiving_reg <= receiving_next;
        end
    end

    // -------------------------------------------------------------------
    // flags, interrupt, bus-off recovery and action pulses
    // -------------------------------------------------------------------
    logic [BW-1:0] runs_reg;
    logic [BW-1:0] runs_next;
    logic [1:0] flag_reg;
    logic [1:0] flag_next;
    logic [1:0] irq_en_reg;
    logic [1:0] irq_en_next;
    logic [1:0] clr_bits;
    logic       tx_flag_reg;
    logic [9:0] pulse_reg;
    logic [9:0] pulse_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] status;

    assign status = {2'b00, receiving_reg, tx_flag_reg, flag_reg,
                     (state_reg == cmc_pkg::ST_SLEEP), init_ack_reg}; // [R11] [R14] [R17]
    assign clr_bits = ({2{wr_i && addr_i == cmc_pkg::OFS_STATUS}}
                      | {2{wr_i && addr_i == cmc_pkg::OFS_IRQ_CLR}})
                      & wdata_i[cmc_pkg::STA_WAKEUP:cmc_pkg::STA_ERROR];

    always_comb
    begin
        runs_next   = runs_reg;
        irq_en_next = irq_en_reg;
        rdata_next  = cmc_pkg::ZERO_BYTE;
        pulse_next  = '0;
        // software clear first, hardware set wins
        flag_next = flag_reg & ~clr_bits; // [R13]
        if ((state_reg == cmc_pkg::ST_SLEEP) && sof)
            flag_next[1] = 1'b1; // [R12]
        if (error_event_i)
            flag_next[0] = 1'b1;
        if (wr_i && addr_i == cmc_pkg::OFS_IRQ_EN)
            irq_en_next = wdata_i[cmc_pkg::STA_WAKEUP:cmc_pkg::STA_ERROR];
        if (!busoff_i)
            runs_next = '0;
        else if (run_seen)
            runs_next = (runs_reg == RUNS_LAST) ? '0 : runs_reg + RUNS_ONE;
        // busoff exit
        pulse_next[0] = busoff_i && (ctrl_reg[cmc_pkg::CTL_AUTO_BUSOFF]
                        ? (run_seen && runs_reg == RUNS_LAST) : sync_done); // [R01]
        // retransmit policy
        pulse_next[1] = tx_end_i && !tx_ok_i && !ctrl_reg[cmc_pkg::CTL_NO_RETX]; // [R03]
        pulse_next[2] = tx_end_i && (tx_ok_i || ctrl_reg[cmc_pkg::CTL_NO_RETX]); // [R03]
        // receive fifo policy
        pulse_next[3] = store_evt && !(fifo_full_i && ctrl_reg[cmc_pkg::CTL_FIFO_LOCK]); // [R16]
        pulse_next[4] = store_evt && fifo_full_i && !ctrl_reg[cmc_pkg::CTL_FIFO_LOCK]; // [R04]
        pulse_next[5] = store_evt && fifo_full_i && ctrl_reg[cmc_pkg::CTL_FIFO_LOCK]; // [R04]
        pulse_next[6] = ctrl_next[cmc_pkg::CTL_TX_CHRONO]; // [R05]
        pulse_next[7] = (state_next == cmc_pkg::ST_INIT);
        pulse_next[8] = (state_next == cmc_pkg::ST_SLEEP);
        pulse_next[9] = |(flag_next & irq_en_next); // [R12]
        if (rd_i)
        begin
            unique case (addr_i)
                cmc_pkg::OFS_CTRL:   rdata_next = ctrl_reg;
                cmc_pkg::OFS_STATUS: rdata_next = status;
                cmc_pkg::OFS_IRQ_EN: rdata_next = {4'h0, irq_en_reg, 2'b00};
                default:             rdata_next = cmc_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            runs_reg    <= '0;
            flag_reg    <= '0;
            irq_en_reg  <= '0;
            tx_flag_reg <= 1'b0;
            pulse_reg   <= 10'h100;
            rdata_reg   <= cmc_pkg::ZERO_BYTE;
        end
        else
        begin
            runs_reg    <= runs_next;
            flag_reg    <= flag_next;
            irq_en_reg  <= irq_en_next;
            tx_flag_reg <= tx_active_i; // [R11]
            pulse_reg   <= pulse_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign busoff_leave_o           = pulse_reg[0];
    assign tx_retry_o               = pulse_reg[1];
    assign tx_release_o             = pulse_reg[2];
    assign fifo_store_o             = pulse_reg[3];
    assign fifo_overwrite_o         = pulse_reg[4];
    assign fifo_discard_o           = pulse_reg[5];
    assign tx_order_chronological_o = pulse_reg[6];
    assign init_mode_o              = pulse_reg[7];
    assign sleep_mode_o             = pulse_reg[8];
    assign irq_o                    = pulse_reg[9];
    assign rdata_o                  = rdata_reg;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_busoff_manual: assert property (busoff_leave_o |-> $past(ctrl_reg[cmc_pkg::CTL_AUTO_BUSOFF])
        || $past(sync_done)) else $error("bus-off left without cause"); // [R01]
    chk_sleep_hold: assert property ((state_reg == cmc_pkg::ST_SLEEP)
        && ctrl_reg[cmc_pkg::CTL_SLEEP_REQ] && !auto_wake |=> (state_reg == cmc_pkg::ST_SLEEP))
        else $error("sleep left without request"); // [R02]
    chk_auto_wake: assert property (auto_wake |=> !ctrl_reg[cmc_pkg::CTL_SLEEP_REQ]
        ##1 !status[cmc_pkg::STA_SLEEP_ACK]) else $error("auto wake failed"); // [R07]
    chk_single_shot: assert property (tx_end_i && ctrl_reg[cmc_pkg::CTL_NO_RETX]
        |=> tx_release_o && !tx_retry_o) else $error("retry with retransmit off"); // [R03]
    chk_fifo_lock: assert property (store_evt && fifo_full_i && ctrl_reg[cmc_pkg::CTL_FIFO_LOCK]
        |=> fifo_discard_o && !fifo_store_o) else $error("locked fifo overwritten"); // [R04]
    chk_tx_order: assert property (wr_ctrl |=> tx_order_chronological_o
        == $past(wdata_i[cmc_pkg::CTL_TX_CHRONO])) else $error("order bit not applied"); // [R05]
    chk_sleep_wait: assert property ((state_reg == cmc_pkg::ST_NORMAL) && busy
        |=> state_reg != cmc_pkg::ST_SLEEP) else $error("sleep during frame"); // [R06]
    chk_sync_wait: assert property ($fell(init_ack_reg) && !$past(state_reg == cmc_pkg::ST_INIT)
        |-> $past(run_seen)) else $error("init ack cleared unsynchronised"); // [R08]
    chk_init_ack: assert property (init_mode_o |-> init_ack_reg)
        else $error("init mode without ack"); // [R09]
    chk_reset_val: assert property (disable iff (1'b0) !rst_n_i |-> ctrl_reg == cmc_pkg::CTRL_RESET
        && status == cmc_pkg::STATUS_RESET) else $error("bad reset value"); // [R10]
    chk_tx_flag: assert property (##1 status[cmc_pkg::STA_TRANSMIT] == $past(tx_active_i))
        else $error("transmit flag wrong"); // [R11]
    chk_wake_flag: assert property ((state_reg == cmc_pkg::ST_SLEEP) && sof
        |=> flag_reg[1] ##1 (irq_o || !irq_en_reg[1])) else $error("wake flag missed"); // [R12]
    chk_w1c: assert property (clr_bits[1] && !sof |=> !flag_reg[1])
        else $error("wake flag not cleared"); // [R13]
    chk_reserved: assert property (rdata_o[7:6] == 2'b00)
        else $error("reserved bits set"); // [R14]
    chk_rx_end: assert property ($fell(receiving_reg) |-> $past(rx_cnt_reg)
        == cmc_pkg::RX_END_BITS - cmc_pkg::CNT_ONE || $past(rx_start_i))
        else $error("rx end early"); // [R15]
    chk_store_time: assert property (fifo_store_o || fifo_discard_o |-> $past(rx_cnt_reg)
        == cmc_pkg::STORE_BITS - cmc_pkg::CNT_ONE) else $error("store at wrong time"); // [R16]
    chk_sleep_ack: assert property (##1 status[cmc_pkg::STA_SLEEP_ACK] == sleep_mode_o)
        else $error("sleep ack mismatch"); // [R17]

    cov_auto_wake: cover property (auto_wake);
    cov_sync_done: cover property (sync_done);
    cov_overwrite: cover property (fifo_overwrite_o);
    cov_busoff_auto: cover property (busoff_leave_o && ctrl_reg[cmc_pkg::CTL_AUTO_BUSOFF]);
endmodule // cmc_mode_ctrl
`default_nettype wire

// ---- cmc_pkg.sv ----
// constants, register map and state codes of the mode control block
// assumes an 8-bit register port and a protocol engine on the same clock
//
// Notes on behaviour
// R01: auto recovery off leaves bus-off by software; on, after 128 runs of 11 recessive.
// R02: auto wake-up off waits for software; on, bus activity clears sleep request and ack.
// R03: retransmit off sends each message once; otherwise retry until success.
// R04: lock off overwrites the newest message on full FIFO; lock on discards arrivals.
// R05: priority bit 0 orders by identifier, 1 orders by request time.
// R06: sleep entered only after the current frame ends; clearing the request exits.
// R07: with auto wake-up, start of frame on receive line clears sleep request.
// R08: leaving init waits 11 recessive bits, then clears init acknowledge.
// R09: entering init waits for current activity, then sets init acknowledge.
// R10: control and status registers both reset to 02h.
// R11: read-only flags show receiver and transmitter activity.
// R12: start of frame in sleep sets wake-up flag; enabled flag raises interrupt.
// R13: status flags clear by writing one; writing zero leaves them.
// R14: reserved control bit written zero; reserved status bits read zero.
// R15: receiving flag ends 8 bit times after the acknowledge bit.
// R16: received message stored no earlier than six bits plus sample point after ack.
// R17: sleep acknowledge set in sleep mode and cleared on leaving it.
package cmc_pkg;
    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h1;
    localparam logic [3:0] OFS_IRQ_EN  = 4'h2;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h3;
    // -------------------------------------------------------------------
    // control bit positions
    // -------------------------------------------------------------------
    localparam int CTL_AUTO_BUSOFF = 6;
    localparam int CTL_AUTO_WAKE   = 5;
    localparam int CTL_NO_RETX     = 4;
    localparam int CTL_FIFO_LOCK   = 3;
    localparam int CTL_TX_CHRONO   = 2;
    localparam int CTL_SLEEP_REQ   = 1;
    localparam int CTL_INIT_REQ    = 0;
    localparam logic [7:0] CTL_WMASK = 8'h7F;
    // -------------------------------------------------------------------
    // status bit positions
    // -------------------------------------------------------------------
    localparam int STA_RECEIVING = 5;
    localparam int STA_TRANSMIT  = 4;
    localparam int STA_WAKEUP    = 3;
    localparam int STA_ERROR     = 2;
    localparam int STA_SLEEP_ACK = 1;
    localparam int STA_INIT_ACK  = 0;
    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET   = 8'h02;
    localparam logic [7:0] STATUS_RESET = 8'h02;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    // -------------------------------------------------------------------
    // timing in bit times
    // -------------------------------------------------------------------
    localparam int RECESSIVE_RUN = 11;
    localparam int BUSOFF_RUNS   = 128;
    localparam logic [3:0] RX_END_BITS = 4'h8;
    localparam logic [3:0] STORE_BITS  = 4'h7;
    localparam logic [3:0] CNT_ONE     = 4'h1;
    // -------------------------------------------------------------------
    // operating modes
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_SLEEP  = 4'b0001,
        ST_INIT   = 4'b0010,
        ST_SYNC   = 4'b0100,
        ST_NORMAL = 4'b1000
    } cmc_state_type;
endpackage

// ---- cmc_run_detect.sv ----
// detector of a run of consecutive recessive bits
// assumes bit_tick_i marks each sample point, rx_i already synchronised
`timescale 1ns/1ns
`default_nettype none
module cmc_run_detect #(
    parameter int RUN_LEN = 11
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic bit_tick_i,
    input  wire logic rx_i,
    input  wire logic clear_i,
    output logic      run_o
);
    localparam int CW = $clog2(RUN_LEN + 1);
    localparam logic [CW-1:0] LAST = CW'(RUN_LEN - 1);
    localparam logic [CW-1:0] ONE  = CW'(1);

    initial
    begin
        if (RUN_LEN < 2) $error("run length too short");
    end

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          run_reg;
    logic          run_next;

    // -------------------------------------------------------------------
    // counting
    // -------------------------------------------------------------------
    always_comb
    begin
        cnt_next = cnt_reg;
        run_next = 1'b0;
        if (clear_i)
            cnt_next = '0;
        else if (bit_tick_i)
        begin
            if (!rx_i)
                cnt_next = '0;
            else if (cnt_reg == LAST)
            begin
                cnt_next = '0;
                run_next = 1'b1;
            end
            else
                cnt_next = cnt_reg + ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
        end
    end

    assign run_o = run_reg;
endmodule // cmc_run_detect
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench of the mode control block
// assumes the bus model for ticks and the receive line
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr_s = 1'b0, rd_s = 1'b0, sof = 1'b0, rx_start = 1'b0, ack_end = 1'b0;
    logic       tx_act = 1'b0, tx_end = 1'b0, tx_ok = 1'b0, busoff = 1'b0, full = 1'b0;
    logic       can_rx, tick, retry, rel, ovw, disc, leave, chrono, sleep_m, irq, init_m, store;
    logic [7:0] rdata, r;
    logic [2:0] seen = 3'b000;
    int         errors = 0, check_count = 0;
    always #25 clk = ~clk;
    // fifo actions seen since the last acknowledge end
    always @(posedge clk) seen <= ack_end ? 3'b000 : (seen | {store, ovw, disc});
    cmc_bus_model cmc_bus_model_inst (.clk_i(clk), .sof_i(sof), .can_rx_o(can_rx),
        .bit_tick_o(tick));
    cmc_mode_ctrl #(.RECOVERY_RUNS(2)) cmc_mode_ctrl_inst (.clk_i(clk), .rst_n_i(rst_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
        .can_rx_i(can_rx), .bit_tick_i(tick), .rx_start_i(rx_start), .ack_end_i(ack_end),
        .tx_active_i(tx_act), .tx_end_i(tx_end), .tx_ok_i(tx_ok), .error_event_i(1'b0),
        .busoff_i(busoff), .fifo_full_i(full), .init_mode_o(init_m), .sleep_mode_o(sleep_m),
        .tx_order_chronological_o(chrono), .tx_retry_o(retry), .tx_release_o(rel),
        .fifo_store_o(store), .fifo_overwrite_o(ovw), .fifo_discard_o(disc),
        .busoff_leave_o(leave), .irq_o(irq));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        @(negedge clk) `CHK(rdata, e)
        @(posedge clk);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk iff tick);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog: all tests need well under 3000 cycles
    initial
    begin
        #2000000;
        errors++;
        results();
    end
    initial
    begin
        rst_n <= 1'b0;
        void'($urandom(32'h68a5));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(4'h0, 8'h02);
        rdc(4'h1, 8'h02);
        rdc(4'h7, 8'h00);
        r = 8'($urandom);
        wr(4'h0, {1'b0, r[6:2], 2'b01});
        rdc(4'h0, {1'b0, r[6:2], 2'b01});
        `CHK(chrono, r[2])
        rdc(4'h1, 8'h01);
        `CHK(init_m, 1'b1)
        wr(4'h0, 8'h00);
        ticks(13);
        rdc(4'h1, 8'h00);
        `CHK(init_m, 1'b0)
        $display("test modes done");
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h0, {3'b000, i[0], 4'h0});
            tx_end <= 1'b1;
            tx_ok <= i[1];
            @(posedge clk) tx_end <= 1'b0;
            @(negedge clk) `CHK({retry, rel}, {~i[1] & ~i[0], i[1] | i[0]})
            @(posedge clk);
        end
        $display("test transmit done");
        full <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            wr(4'h0, {4'h0, i[0], 3'b000});
            rx_start <= 1'b1;
            @(posedge clk) rx_start <= 1'b0;
            ack_end <= 1'b1;
            @(posedge clk) ack_end <= 1'b0;
            ticks(6);
            `CHK(seen, 3'b000)
            rdc(4'h1, 8'h20);
            ticks(2);
            repeat (2) @(posedge clk);
            `CHK(seen, {~i[0], ~i[0], i[0]})
            rdc(4'h1, 8'h00);
        end
        $display("test receive done");
        wr(4'h2, 8'h08);
        tx_act <= 1'b1;
        wr(4'h0, 8'h22);
        repeat (4) @(posedge clk);
        `CHK(sleep_m, 1'b0)
        rdc(4'h1, 8'h10);
        tx_act <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(sleep_m, 1'b1)
        rdc(4'h1, 8'h02);
        sof <= 1'b1;
        @(posedge clk) sof <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(irq, 1'b1)
        rdc(4'h0, 8'h20);
        rdc(4'h1, 8'h08);
        wr(4'h1, 8'h00);
        rdc(4'h1, 8'h08);
        wr(4'h1, 8'h08);
        rdc(4'h1, 8'h00);
        `CHK(irq, 1'b0)
        $display("test sleep done");
        wr(4'h0, 8'h40);
        ticks(13);
        busoff <= 1'b1;
        for (int k = 0; k < 400 && leave !== 1'b1; k++) @(negedge clk);
        `CHK(leave, 1'b1)
        $display("test recovery done");
        @(posedge clk);
        wr(4'h0, 8'h01);
        rdc(4'h1, 8'h01);
        wr(4'h0, 8'h00);
        for (int k = 0; k < 400 && leave !== 1'b1; k++) @(negedge clk);
        `CHK(leave, 1'b1)
        @(posedge clk);
        rdc(4'h1, 8'h00);
        $display("test manual recovery done");
        wr(4'h0, 8'h02);
        sof <= 1'b1;
        @(posedge clk) sof <= 1'b0;
        repeat (8) @(posedge clk);
        rdc(4'h1, 8'h0A);
        rdc(4'h0, 8'h02);
        wr(4'h0, 8'h00);
        rdc(4'h1, 8'h08);
        $display("test manual wake done");
        results();
    end
endmodule // testbench
`default_nettype wire
